/* pkg/power_removal_pkg.sv */
/*
  Constants, register map and types for the power removal control block.
  Assumes a 100 MHz system clock and a classic Wishbone register bus.
*/
package power_removal_pkg;

  // Clock and time base
  localparam int CLK_PERIOD_NS     = 10;
  localparam int MS_PERIOD_NS      = 1000000;
  localparam int MS_CYCLES_DEFAULT = (MS_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MS_CNT_W          = 17;

  // Removal timing, in milliseconds
  localparam int REMOVAL_MAX_MS    = 15;
  // Dwell well inside the 15 ms budget: tick jitter adds up to 1 ms
  localparam int DWELL_MS          = 10;
  localparam int DWELL_W           = 4;
  localparam logic [DWELL_W-1:0] DWELL_TICKS = DWELL_W'(DWELL_MS);
  localparam int BLINK_HALF_MS     = 250;
  localparam int BLINK_W           = 8;
  localparam logic [BLINK_W-1:0] BLINK_TICKS = BLINK_W'(BLINK_HALF_MS - 1);

  // Register byte offsets
  localparam logic [7:0] CTRL_OFFSET      = 8'h00;
  localparam logic [7:0] STATUS_OFFSET    = 8'h04;
  localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h08;
  localparam logic [7:0] IRQ_MASK_OFFSET  = 8'h0c;

  // Control fields
  localparam int CTRL_EXC_CMD_BIT  = 0;
  localparam int CTRL_MODE_BIT     = 1;
  localparam logic CTRL_EXC_CMD_RESET = 1'b0;
  localparam logic CTRL_MODE_RESET    = 1'b0;

  // Status fields
  localparam int STAT_REMOVAL_BIT  = 0;
  localparam int STAT_EXCITED_BIT  = 1;
  localparam int STAT_UPPER_BIT    = 2;
  localparam int STAT_LOWER_BIT    = 3;
  localparam int STAT_MONITOR_BIT  = 4;
  localparam int STAT_MISMATCH_BIT = 5;

  // Interrupt fields
  localparam int IRQ_W             = 3;
  localparam int IRQ_ENTER_BIT     = 0;
  localparam int IRQ_RELEASE_BIT   = 1;
  localparam int IRQ_MISMATCH_BIT  = 2;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;

  typedef enum logic [1:0] {
    ST_RELEASED,
    ST_REMOVAL,
    ST_RUN
  } removal_state_e;

endpackage : power_removal_pkg

/* hdl/dwell_timer.sv */
/*
  Dwell timer: reports that a condition has held for a fixed number of
  millisecond ticks. Assumes cond_i is already synchronous to clk_i.
*/
`timescale 1ns/10ps
module dwell_timer (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Time base and condition
  input  wire logic tick_i,
  input  wire logic cond_i,
  // Result
  output logic      done_o
);
  import power_removal_pkg::*;

  typedef struct packed {
    logic [DWELL_W-1:0] cnt;
    logic               done;
  } dwell_s;

  dwell_s r_reg;
  dwell_s r_next;

  always_comb begin
    r_next = r_reg;
    if (!cond_i) begin
      r_next.cnt  = '0;
      r_next.done = 1'b0;
    end else if (tick_i && !r_reg.done) begin
      // A partial first tick counts, so the dwell is between N-1 and N ms
      r_next.cnt  = r_reg.cnt + DWELL_W'(1);
      r_next.done = (r_reg.cnt + DWELL_W'(1)) >= DWELL_TICKS;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign done_o = r_reg.done;

endmodule : dwell_timer

/* hdl/power_removal_control.sv */
/*
  Power removal control: gates the inverter arm drives from two removal
  inputs, sequences removal, release and re-excitation, and drives the
  status outputs, fault monitor and a Wishbone register file with an
  interrupt. Assumes removal and clear inputs come from external pins and
  that drive and bus signals are synchronous to clk_i.
*/
// Our own choices: the Wishbone interface to the registers and the register offsets.
// Functional notes
// - Both inputs off: removal state, motor unexcited
// - Upper input gates upper arm, lower gates lower
// - Mode 0 status behaviour; mode resets to 0
// - Removal: indicator on, ready outputs and brake off
// - Removal: green blink, brake holds shaft
// - Enter removal within 15 ms of both off
// - Both on: leave removal, stay unexcited
// - Re-excite on clear edge with excitation command
// - Clear: indicator off, ready and brake on, steady
// - One input on keeps removal state
// - Monitor on only when both inputs off
// - One input on: monitor off, motor unexcited
`timescale 1ns/10ps
module power_removal_control #(
  parameter int MS_CYCLES = power_removal_pkg::MS_CYCLES_DEFAULT
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Removal and clear pins, active high means contact on
  input  wire logic        removal_input_upper_i,
  input  wire logic        removal_input_lower_i,
  input  wire logic        excitation_off_clear_i,
  // Inverter arm drives from the current loop
  input  wire logic        gate_upper_i,
  input  wire logic        gate_lower_i,
  // Gated inverter arm drives
  output logic             drive_upper_o,
  output logic             drive_lower_o,
  // Status outputs
  output logic             motor_excite_o,
  output logic             excitation_off_indicator_o,
  output logic             drive_command_ready_o,
  output logic             ready_o,
  output logic             brake_control_output_o,
  output logic             power_alarm_indicator_o,
  output logic             alarm_o,
  output logic             removal_fault_monitor_o,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // Interrupt
  output logic             irq_o
);
  import power_removal_pkg::*;

  typedef struct packed {
    removal_state_e     st;
    logic [MS_CNT_W-1:0] ms_cnt;
    logic               tick;
    logic [BLINK_W-1:0] blink_cnt;
    logic               blink;
    logic [1:0]         up_sync;
    logic [1:0]         lo_sync;
    logic [1:0]         clr_sync;
    logic               clr_prev;
    logic               exc_cmd;
    logic               mode;
    logic [IRQ_W-1:0]   irq_st;
    logic [IRQ_W-1:0]   irq_mask;
    logic               ack;
    logic [31:0]        dat;
    logic               drv_up;
    logic               drv_lo;
    logic               excite;
    logic               eto_ind;
    logic               drive_command_ready;
    logic               rdy;
    logic               brake;
    logic               led;
    logic               alarm;
    logic               monitor;
    logic               irq;
  } ctrl_s;

  ctrl_s r_reg;
  ctrl_s r_next;

  logic up_on;
  logic lo_on;
  logic off_done;
  logic on_done;
  logic mis_done;
  logic clr_edge;
  logic bus_req;
  logic bus_wr;
  logic [IRQ_W-1:0] events;
  logic [IRQ_W-1:0] w1c;

  function automatic logic sel_hit(input logic [7:0] adr, input logic [7:0] off);
    sel_hit = (adr[7:2] == off[7:2]);
  endfunction : sel_hit

  assign up_on    = r_reg.up_sync[1];
  assign lo_on    = r_reg.lo_sync[1];
  assign clr_edge = r_reg.clr_sync[1] && !r_reg.clr_prev;
  assign bus_req  = wb_cyc_i && wb_stb_i && !r_reg.ack;
  assign bus_wr   = bus_req && wb_we_i && wb_sel_i[0];

  dwell_timer u_off_dwell (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .tick_i (r_reg.tick),
    .cond_i (!up_on && !lo_on),
    .done_o (off_done)
  );

  dwell_timer u_on_dwell (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .tick_i (r_reg.tick),
    .cond_i (up_on && lo_on),
    .done_o (on_done)
  );

  // A transient skew between the two contacts is not a wiring fault
  dwell_timer u_mis_dwell (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .tick_i (r_reg.tick),
    .cond_i (up_on != lo_on),
    .done_o (mis_done)
  );

  always_comb begin
    r_next = r_reg;
    events = '0;
    w1c    = '0;

    // Pin synchronisers
    r_next.up_sync  = {r_reg.up_sync[0], removal_input_upper_i};
    r_next.lo_sync  = {r_reg.lo_sync[0], removal_input_lower_i};
    r_next.clr_sync = {r_reg.clr_sync[0], excitation_off_clear_i};
    r_next.clr_prev = r_reg.clr_sync[1];

    // Millisecond time base
    r_next.tick = 1'b0;
    if (r_reg.ms_cnt >= MS_CNT_W'(MS_CYCLES - 1)) begin
      r_next.ms_cnt = '0;
      r_next.tick   = 1'b1;
    end else begin
      r_next.ms_cnt = r_reg.ms_cnt + MS_CNT_W'(1);
    end

    if (r_reg.tick) begin
      if (r_reg.blink_cnt >= BLINK_TICKS) begin
        r_next.blink_cnt = '0;
        r_next.blink     = !r_reg.blink;
      end else begin
        r_next.blink_cnt = r_reg.blink_cnt + BLINK_W'(1);
      end
    end

    // Sequencer
    case (r_reg.st)
      ST_RUN: begin
        if (off_done) begin
          r_next.st = ST_REMOVAL;
          events[IRQ_ENTER_BIT] = 1'b1;
        end else if (mis_done) begin
          r_next.st = ST_RELEASED;
        end
      end
      ST_REMOVAL: begin
        if (on_done) begin
          r_next.st = ST_RELEASED;
          events[IRQ_RELEASE_BIT] = 1'b1;
        end
      end
      ST_RELEASED: begin
        if (off_done) begin
          r_next.st = ST_REMOVAL;
          events[IRQ_ENTER_BIT] = 1'b1;
        end else if (clr_edge && r_reg.exc_cmd && up_on && lo_on && !mis_done) begin
          r_next.st = ST_RUN;
        end
      end
      default: begin
        r_next.st = ST_RELEASED;
      end
    endcase

    if (mis_done && (up_on != lo_on)) begin
      events[IRQ_MISMATCH_BIT] = 1'b1;
    end

    // Arm gating follows each contact directly, independent of the sequencer
    r_next.drv_up = gate_upper_i && up_on;
    r_next.drv_lo = gate_lower_i && lo_on;

    // Status outputs, mode 0 behaviour except alarm, which is set in removal when mode is 1
    r_next.excite   = (r_next.st == ST_RUN);
    r_next.eto_ind  = (r_next.st != ST_RUN);
    r_next.drive_command_ready = (r_next.st == ST_RUN);
    r_next.rdy      = (r_next.st == ST_RUN);
    r_next.brake    = (r_next.st == ST_RUN);
    r_next.led      = (r_next.st == ST_REMOVAL) ? r_reg.blink : 1'b1;
    r_next.alarm    = (r_next.st == ST_REMOVAL) && r_reg.mode;
    r_next.monitor  = !up_on && !lo_on;

    // Register bus
    r_next.ack = bus_req;
    if (bus_req) begin
      r_next.dat = '0;
      if (sel_hit(wb_adr_i, CTRL_OFFSET)) begin
        r_next.dat[CTRL_EXC_CMD_BIT] = r_reg.exc_cmd;
        r_next.dat[CTRL_MODE_BIT]    = r_reg.mode;
      end else if (sel_hit(wb_adr_i, STATUS_OFFSET)) begin
        r_next.dat[STAT_REMOVAL_BIT]  = (r_reg.st == ST_REMOVAL);
        r_next.dat[STAT_EXCITED_BIT]  = (r_reg.st == ST_RUN);
        r_next.dat[STAT_UPPER_BIT]    = up_on;
        r_next.dat[STAT_LOWER_BIT]    = lo_on;
        r_next.dat[STAT_MONITOR_BIT]  = r_reg.monitor;
        r_next.dat[STAT_MISMATCH_BIT] = mis_done;
      end else if (sel_hit(wb_adr_i, IRQ_STATUS_OFFSET)) begin
        r_next.dat[IRQ_W-1:0] = r_reg.irq_st;
      end else if (sel_hit(wb_adr_i, IRQ_MASK_OFFSET)) begin
        r_next.dat[IRQ_W-1:0] = r_reg.irq_mask;
      end
    end

    if (bus_wr) begin
      if (sel_hit(wb_adr_i, CTRL_OFFSET)) begin
        r_next.exc_cmd = wb_dat_i[CTRL_EXC_CMD_BIT];
        r_next.mode    = wb_dat_i[CTRL_MODE_BIT];
      end else if (sel_hit(wb_adr_i, IRQ_STATUS_OFFSET)) begin
        w1c = wb_dat_i[IRQ_W-1:0];
      end else if (sel_hit(wb_adr_i, IRQ_MASK_OFFSET)) begin
        r_next.irq_mask = wb_dat_i[IRQ_W-1:0];
      end
    end

    // A new event in the clearing cycle survives the clear
    r_next.irq_st = (r_reg.irq_st & ~w1c) | events;
    r_next.irq    = |(r_next.irq_st & r_next.irq_mask);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r_reg          <= '0;
      r_reg.st       <= ST_RELEASED;
      r_reg.exc_cmd  <= CTRL_EXC_CMD_RESET;
      r_reg.mode     <= CTRL_MODE_RESET;
      r_reg.irq_st   <= IRQ_RESET;
      r_reg.irq_mask <= IRQ_RESET;
      r_reg.eto_ind  <= 1'b1;
      r_reg.led      <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  assign drive_upper_o              = r_reg.drv_up;
  assign drive_lower_o              = r_reg.drv_lo;
  assign motor_excite_o             = r_reg.excite;
  assign excitation_off_indicator_o = r_reg.eto_ind;
  assign drive_command_ready_o      = r_reg.drive_command_ready;
  assign ready_o                    = r_reg.rdy;
  assign brake_control_output_o     = r_reg.brake;
  assign power_alarm_indicator_o    = r_reg.led;
  assign alarm_o                    = r_reg.alarm;
  assign removal_fault_monitor_o    = r_reg.monitor;
  assign wb_dat_o                   = r_reg.dat;
  assign wb_ack_o                   = r_reg.ack;
  assign irq_o                      = r_reg.irq;

endmodule : power_removal_control

/* verif/power_removal_asserts.sv */
/* Port checker for power_removal_control.
   Assumes it is bound to the top module with the same MS_CYCLES. */
`timescale 1ns/10ps
module power_removal_checker #(
  parameter int MS_CYCLES = 20
) (
  input wire logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_ack_o,
  input wire logic removal_input_upper_i, removal_input_lower_i, excitation_off_clear_i,
  input wire logic gate_upper_i, drive_upper_o, drive_lower_o, motor_excite_o,
  input wire logic excitation_off_indicator_o, drive_command_ready_o, ready_o,
  input wire logic brake_control_output_o, power_alarm_indicator_o, removal_fault_monitor_o
);
  // Margin covers the pin sync and state register stages
  localparam int unsigned LIMIT = 15 * MS_CYCLES + 4;
  int unsigned off_cnt;
  logic        both_off;
  assign both_off = !removal_input_upper_i && !removal_input_lower_i;
  always_ff @(posedge clk_i) begin
    if (rst_i || !both_off) begin
      off_cnt <= 0;
    end else if (off_cnt < LIMIT) begin
      off_cnt <= off_cnt + 1;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_upper_block: assert property ((!removal_input_upper_i)[*3] |=> !drive_upper_o)
    else $error("upper arm not blocked");
  a_lower_block: assert property ((!removal_input_lower_i)[*3] |=> !drive_lower_o)
    else $error("lower arm not blocked");
  a_gate_follow: assert property (drive_upper_o |-> $past(gate_upper_i))
    else $error("upper arm driven without gate");
  a_monitor_on: assert property (both_off[*3] |=> removal_fault_monitor_o)
    else $error("monitor off with both inputs off");
  a_monitor_off: assert property ((!both_off)[*3] |=> !removal_fault_monitor_o)
    else $error("monitor on with an input on");
  a_removal_bound: assert property (off_cnt == LIMIT |-> excitation_off_indicator_o
    && !motor_excite_o) else $error("removal not reached in time");
  a_removal_outs: assert property (excitation_off_indicator_o |-> !ready_o
    && !drive_command_ready_o && !brake_control_output_o) else $error("ready while off");
  a_run_outs: assert property (!excitation_off_indicator_o |-> motor_excite_o && ready_o
    && drive_command_ready_o && brake_control_output_o && power_alarm_indicator_o)
    else $error("run outputs inconsistent");
  a_blink_brake: assert property (!power_alarm_indicator_o |-> excitation_off_indicator_o
    && !brake_control_output_o) else $error("blink outside removal");
  a_excite_cause: assert property ($rose(motor_excite_o) |-> $past(excitation_off_clear_i, 2)
    && removal_input_upper_i && removal_input_lower_i) else $error("excited without clear");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing");
  c_removal: cover property ($rose(removal_fault_monitor_o));
  c_run: cover property ($rose(motor_excite_o));
  c_blink: cover property ($fell(power_alarm_indicator_o));
endmodule : power_removal_checker
bind power_removal_control power_removal_checker #(.MS_CYCLES(MS_CYCLES)) chk (.*);

/* verif/contact_model.sv */
/* Model of the external contacts on the removal and clear pins.
   Assumes requests are posted just after a rising edge. */
`timescale 1ns/10ps
module contact_model #(
  parameter int HOLD = 300
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic want_upper_i,
  input  wire logic want_lower_i,
  input  wire logic want_clear_i,
  output logic      upper_o,
  output logic      lower_o,
  output logic      clear_o
);
  int unsigned held;
  always_ff @(posedge clk_i) begin
    clear_o <= want_clear_i;
    if (rst_i) begin
      upper_o <= 1'b1;
      lower_o <= 1'b1;
      held    <= 0;
    end else if (held < HOLD) begin
      // Shorter dwells may leave the device undecided, so each state is kept
      held <= held + 1;
    end else if ({upper_o, lower_o} != {want_upper_i, want_lower_i}) begin
      upper_o <= want_upper_i;
      lower_o <= want_lower_i;
      held    <= 0;
    end
  end
endmodule : contact_model

/* verif/test_power_removal_control.sv */
/* Self-checking bench for power_removal_control.
   Assumes the contact model drives the pins and a Wishbone master task. */
`timescale 1ns/10ps
module test_power_removal_control;
  import power_removal_pkg::*;
  localparam int MS = 20;
  logic        clk_i, rst_i, want_upper, want_lower, want_clear, led_prev;
  logic        removal_input_upper_i, removal_input_lower_i, excitation_off_clear_i;
  logic        gate_upper_i, gate_lower_i, drive_upper_o, drive_lower_o, alarm_o;
  logic        motor_excite_o, excitation_off_indicator_o, drive_command_ready_o, ready_o;
  logic        brake_control_output_o, power_alarm_indicator_o, removal_fault_monitor_o;
  logic        wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  int          fails, n_compared, toggles;
  contact_model #(.HOLD(15 * MS)) contacts (
    .clk_i(clk_i), .rst_i(rst_i), .want_upper_i(want_upper), .want_lower_i(want_lower),
    .want_clear_i(want_clear), .upper_o(removal_input_upper_i),
    .lower_o(removal_input_lower_i), .clear_o(excitation_off_clear_i));
  power_removal_control #(.MS_CYCLES(MS)) dut (.*);
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic wb_xfer(input logic wr, input logic [7:0] adr, input logic [31:0] wdat);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= wr;
    wb_adr_i <= adr;
    wb_dat_i <= wdat;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    rd = wb_dat_o;
    if (wb_ack_o !== 1'b1) fails++;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb_xfer
  task automatic rd_check(input string name, input logic [7:0] adr, input logic [31:0] exp);
    wb_xfer(1'b0, adr, 32'h0);
    check(name, rd, exp);
  endtask : rd_check
  task automatic clear_pulse;
    want_clear <= 1'b1;
    repeat (12) @(posedge clk_i);
    want_clear <= 1'b0;
    repeat (12) @(posedge clk_i);
  endtask : clear_pulse
  task automatic print_verdict;
    $display("Compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : print_verdict
  initial begin
    repeat (40000) @(posedge clk_i);
    fails++;
    print_verdict();
  end
  initial begin
    {rst_i, want_upper, want_lower, want_clear, gate_upper_i, gate_lower_i} = 6'h38;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} = {43'h0, 4'hf};
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check("reset outputs", 32'({motor_excite_o, ready_o, excitation_off_indicator_o,
      power_alarm_indicator_o}), 32'h3);
    rd_check("ctrl reset", CTRL_OFFSET, 32'h0);
    rd_check("mask reset", IRQ_MASK_OFFSET, 32'h0);
    rd_check("unmapped", 8'h10, 32'h0);
    repeat (16 * MS) @(posedge clk_i);
    clear_pulse();
    check("clear without command", 32'(motor_excite_o), 32'h0);
    wb_xfer(1'b1, CTRL_OFFSET, 32'h1);
    wb_xfer(1'b1, IRQ_MASK_OFFSET, 32'h1);
    clear_pulse();
    {gate_upper_i, gate_lower_i} <= 2'b11;
    repeat (4) @(posedge clk_i);
    check("run outputs", 32'({motor_excite_o, drive_command_ready_o, ready_o,
      brake_control_output_o, excitation_off_indicator_o, power_alarm_indicator_o,
      drive_upper_o, drive_lower_o}), 32'hf7);
    rd_check("run status", STATUS_OFFSET, 32'h0e);
    // Loop stops the motor before the contacts open
    {gate_upper_i, gate_lower_i, want_upper, want_lower} <= 4'h0;
    repeat (16 * MS) @(posedge clk_i);
    {gate_upper_i, gate_lower_i} <= 2'b11;
    repeat (4) @(posedge clk_i);
    check("removal outputs", 32'({motor_excite_o, drive_command_ready_o, ready_o,
      brake_control_output_o, excitation_off_indicator_o, alarm_o, removal_fault_monitor_o,
      drive_upper_o, drive_lower_o}), 32'h14);
    rd_check("removal status", STATUS_OFFSET, 32'h11);
    check("irq on entry", 32'(irq_o), 32'h1);
    // Alarm variant of the mode setting, then back to the default mode
    wb_xfer(1'b1, CTRL_OFFSET, 32'h3);
    check("mode 1 alarm", 32'(alarm_o), 32'h1);
    wb_xfer(1'b1, CTRL_OFFSET, 32'h1);
    check("mode 0 no alarm", 32'(alarm_o), 32'h0);
    led_prev = power_alarm_indicator_o;
    repeat (600 * MS) begin
      @(posedge clk_i);
      if (power_alarm_indicator_o !== led_prev) toggles++;
      led_prev = power_alarm_indicator_o;
    end
    check("blink count", 32'(toggles inside {[2:3]}), 32'h1);
    wb_xfer(1'b1, IRQ_STATUS_OFFSET, 32'h1);
    check("irq cleared", 32'(irq_o), 32'h0);
    want_upper <= 1'b1;
    repeat (16 * MS) @(posedge clk_i);
    rd_check("one input on", STATUS_OFFSET, 32'h25);
    check("one on outputs", 32'({removal_fault_monitor_o, motor_excite_o, drive_upper_o,
      drive_lower_o}), 32'h2);
    // Port view: monitor output must equal both removal pins off
    check("valid combination", 32'(removal_fault_monitor_o ==
      (!removal_input_upper_i && !removal_input_lower_i)), 32'h1);
    want_lower <= 1'b1;
    repeat (16 * MS) @(posedge clk_i);
    rd_check("released", STATUS_OFFSET, 32'h0c);
    check("released outputs", 32'({motor_excite_o, excitation_off_indicator_o,
      power_alarm_indicator_o, irq_o}), 32'h6);
    rd_check("events", IRQ_STATUS_OFFSET, 32'h6);
    clear_pulse();
    check("re-excited", 32'(motor_excite_o), 32'h1);
    print_verdict();
  end
endmodule : test_power_removal_control
